/* File: acp_core_model.sv */
`timescale 1ns/10ps

// ****
// Comparator cores
// ****
module acp_core_model (
    input wire logic [15:0] plus_lvl_i,
    input wire logic [15:0] minus_lvl_i,
    output logic [1:0] raw_o
);
    // Ideal cores, no offset or noise
    assign raw_o[0] = plus_lvl_i[7:0] > minus_lvl_i[7:0];
    assign raw_o[1] = plus_lvl_i[15:8] > minus_lvl_i[15:8];
endmodule : acp_core_model

/* File: acp_edge.sv */
`timescale 1ns/10ps

module acp_edge (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic raw_i,
    input wire logic enable_i,
    input wire acp_pkg::acp_edge_t mode_i,
    output logic state_o,
    output logic event_o
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic state_ff;
    logic event_ff;
    logic nxt_state;
    logic nxt_event;

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= raw_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // ****************************************************************
    // Level and edge decode
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        if (!enable_i) begin
            nxt_state = 1'b0;
        end else if (s2_ff == s3_ff) begin
            nxt_state = s3_ff;
        end
        // Disabling must not look like a falling edge
        case (mode_i)
            acp_pkg::ACP_EDGE_ANY_TOGGLE: nxt_event = enable_i & (nxt_state ^ state_ff);
            acp_pkg::ACP_EDGE_FALL: nxt_event = enable_i & state_ff & ~nxt_state;
            acp_pkg::ACP_EDGE_RISE: nxt_event = nxt_state & ~state_ff;
            default: nxt_event = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff <= 1'b0;
            event_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            event_ff <= nxt_event;
        end
    end

    assign state_o = state_ff;
    assign event_o = event_ff;

    property p_edge_rise;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        event_o && (mode_i == acp_pkg::ACP_EDGE_RISE) |-> state_o && !$past(state_o);
    endproperty
    a_edge_rise: assert property (p_edge_rise) else $error("Rise event without rising level");

    property p_edge_pulse;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        event_o |=> !event_o;
    endproperty
    a_edge_pulse: assert property (p_edge_pulse) else $error("Event pulse longer than a cycle");

    property p_edge_off;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !enable_i |=> !state_o && !event_o;
    endproperty
    a_edge_off: assert property (p_edge_off) else $error("Disabled comparator shows activity");

endmodule : acp_edge

/* File: acp_mux.sv */
`timescale 1ns/10ps
`include "acp_regs.svh"

module acp_mux (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] code_i,
    output logic [7:0] plus_pin_o,
    output logic plus_dac_o,
    output logic [7:0] minus_pin_o,
    output logic minus_dac_o,
    output logic minus_bandgap_o,
    output logic minus_scaler_o
);

    logic [2:0] pcode;
    logic [2:0] ncode;

    assign pcode = code_i[`ACP_PLUS_MSB:`ACP_PLUS_LSB];
    assign ncode = code_i[`ACP_MINUS_MSB:`ACP_MINUS_LSB];

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            plus_pin_o <= 8'h01;
            plus_dac_o <= 1'b0;
            minus_pin_o <= 8'h01;
            minus_dac_o <= 1'b0;
            minus_bandgap_o <= 1'b0;
            minus_scaler_o <= 1'b0;
        end else begin
            plus_pin_o <= (pcode == 3'h7) ? 8'h00 : (8'h01 << pcode);
            plus_dac_o <= (pcode == 3'h7);
            case (ncode)
                3'h0: minus_pin_o <= 8'h01;
                3'h1: minus_pin_o <= 8'h02;
                3'h2: minus_pin_o <= 8'h08;
                3'h3: minus_pin_o <= 8'h20;
                3'h4: minus_pin_o <= 8'h80;
                default: minus_pin_o <= 8'h00;
            endcase
            minus_dac_o <= (ncode == 3'h5);
            minus_bandgap_o <= (ncode == 3'h6);
            minus_scaler_o <= (ncode == 3'h7);
        end
    end

    property p_plus_onehot;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        $onehot({plus_pin_o, plus_dac_o}) && !plus_pin_o[7];
    endproperty
    a_plus_onehot: assert property (p_plus_onehot) else $error("Plus selection not one-hot");

    property p_minus_pin3;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ncode == 3'h2 |=> minus_pin_o == 8'h08 && !minus_dac_o;
    endproperty
    a_minus_pin3: assert property (p_minus_pin3) else $error("Minus code 2 not routed to pin 3");

endmodule : acp_mux

/* File: acp_pkg.sv */
package acp_pkg;

    typedef enum logic [1:0] {
        ACP_EDGE_ANY_TOGGLE = 2'b00,
        ACP_EDGE_RESERVED = 2'b01,
        ACP_EDGE_FALL = 2'b10,
        ACP_EDGE_RISE = 2'b11
    } acp_edge_t;

    typedef enum logic [1:0] {
        ACP_WIN_ABOVE = 2'b00,
        ACP_WIN_INSIDE = 2'b01,
        ACP_WIN_BELOW = 2'b10,
        ACP_WIN_OUTSIDE = 2'b11
    } acp_win_t;

    typedef enum logic {
        ACP_BUS_IDLE = 1'b0,
        ACP_BUS_ANSWER = 1'b1
    } acp_bus_t;

endpackage : acp_pkg

/* File: acp_regs.svh */
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH

// ********************************************************************
// Register indices, byte address is four times the index
// ********************************************************************
`define ACP_IDX_CTRL0 3'h0
`define ACP_IDX_CTRL1 3'h1
`define ACP_IDX_MUX0 3'h2
`define ACP_IDX_MUX1 3'h3
`define ACP_IDX_PINOUT 3'h4
`define ACP_IDX_WINDOW 3'h6
`define ACP_IDX_STATUS 3'h7

// ********************************************************************
// Field positions
// ********************************************************************
`define ACP_EDGE_MSB 7
`define ACP_EDGE_LSB 6
`define ACP_LVL_MSB 5
`define ACP_LVL_LSB 4
`define ACP_FAST_BIT 3
`define ACP_HYST_MSB 2
`define ACP_HYST_LSB 1
`define ACP_EN_BIT 0
`define ACP_PLUS_MSB 5
`define ACP_PLUS_LSB 3
`define ACP_MINUS_MSB 2
`define ACP_MINUS_LSB 0
`define ACP_MUX_MASK 8'h3F
`define ACP_PINOUT_MASK 8'h03
`define ACP_WEN_BIT 4
`define ACP_WCOND_MSB 3
`define ACP_WCOND_LSB 2
`define ACP_WLVL_MSB 1
`define ACP_WLVL_LSB 0
`define ACP_WINDOW_MASK 8'h1F
`define ACP_ST_WSTATE_MSB 7
`define ACP_ST_WSTATE_LSB 6
`define ACP_ST_STATE1_BIT 5
`define ACP_ST_STATE0_BIT 4
`define ACP_ST_WFLAG_BIT 2
`define ACP_ST_FLAG1_BIT 1
`define ACP_ST_FLAG0_BIT 0

// ********************************************************************
// Reset values
// ********************************************************************
`define ACP_RST_REG 8'h00

`endif

/* File: acp_top.sv */
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/10ps
`include "acp_regs.svh"

// Contract
// - Output one when plus exceeds minus
// - Edge select: toggle, falling, rising; 01 reserved
// - Events fire regardless of interrupt enable
// - Nonzero level enables interrupt, sets priority
// - Fast bit selects high speed, default low power
// - Hysteresis: none, small, large; 11 reserved
// - Bit zero enables the comparator
// - Result updates continuously for software, events
// - Plus select: pins 0-6, converter output
// - Minus select: pins, converter, bandgap, scaler
// - Two comparators with independent registers
// - Pair forms a window monitor
// - Comparator state can drive a pin
// - Window condition: above, inside, below, outside
// - Flags clear on vector or written one

module acp_top (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [1:0] cmp_raw_i,
    output logic [1:0] cmp_enable_o,
    output logic [1:0] cmp_fast_o,
    output logic [1:0] cmp_hyst_small_o,
    output logic [1:0] cmp_hyst_large_o,
    output logic [15:0] plus_pin_o,
    output logic [1:0] plus_dac_o,
    output logic [15:0] minus_pin_o,
    output logic [1:0] minus_dac_o,
    output logic [1:0] minus_bandgap_o,
    output logic [1:0] minus_scaler_o,
    output logic [1:0] cmp_event_o,
    output logic window_event_o,
    output logic [1:0] cmp_irq_o,
    output logic [3:0] cmp_irq_level_o,
    output logic window_irq_o,
    output logic [1:0] window_irq_level_o,
    input wire logic [1:0] cmp_irq_ack_i,
    input wire logic window_irq_ack_i,
    output logic [1:0] cmp_pin_o,
    output logic [1:0] cmp_pin_oe_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0] ctrl_ff [2];
    logic [7:0] mux_ff [2];
    logic [7:0] pinout_ff;
    logic [7:0] window_ff;
    logic [1:0] flag_ff;
    logic wflag_ff;
    logic [1:0] hyst_small_ff;
    logic [1:0] hyst_large_ff;
    logic [1:0] pin_ff;
    logic [1:0] wstate_ff;
    logic wevent_ff;
    logic [31:0] readdata_ff;
    acp_pkg::acp_bus_t bus_ff;
    logic [1:0] state;
    logic [1:0] event_pulse;
    logic [2:0] idx;
    logic wr_fire;
    logic wr_lane;
    logic [7:0] wbyte;
    logic [7:0] status;
    logic [7:0] rd_mux;
    logic [1:0] nxt_wstate;
    logic nxt_wevent;
    logic wen;
    acp_pkg::acp_win_t wcond;

    assign idx = avs_address_i[4:2];
    assign wbyte = avs_writedata_i[7:0];
    assign wr_lane = avs_byteenable_i[0];
    assign wr_fire = avs_write_i && (bus_ff == acp_pkg::ACP_BUS_ANSWER) && wr_lane;
    assign wen = window_ff[`ACP_WEN_BIT];
    assign wcond = acp_pkg::acp_win_t'(window_ff[`ACP_WCOND_MSB:`ACP_WCOND_LSB]);

    // ****************************************************************
    // Per-comparator slices
    // ****************************************************************
    for (genvar g = 0; g < 2; g++) begin : g_cmp
        acp_edge u_edge (
            .ref_clk_i(ref_clk_i),
            .sys_rst_i(sys_rst_i),
            .raw_i(cmp_raw_i[g]),
            .enable_i(ctrl_ff[g][`ACP_EN_BIT]),
            .mode_i(acp_pkg::acp_edge_t'(ctrl_ff[g][`ACP_EDGE_MSB:`ACP_EDGE_LSB])),
            .state_o(state[g]),
            .event_o(event_pulse[g])
        );
        acp_mux u_mux (
            .ref_clk_i(ref_clk_i),
            .sys_rst_i(sys_rst_i),
            .code_i(mux_ff[g]),
            .plus_pin_o(plus_pin_o[g*8 +: 8]),
            .plus_dac_o(plus_dac_o[g]),
            .minus_pin_o(minus_pin_o[g*8 +: 8]),
            .minus_dac_o(minus_dac_o[g]),
            .minus_bandgap_o(minus_bandgap_o[g]),
            .minus_scaler_o(minus_scaler_o[g])
        );
        assign cmp_enable_o[g] = ctrl_ff[g][`ACP_EN_BIT];
        assign cmp_fast_o[g] = ctrl_ff[g][`ACP_FAST_BIT];
        assign cmp_irq_level_o[g*2 +: 2] = ctrl_ff[g][`ACP_LVL_MSB:`ACP_LVL_LSB];
        assign cmp_irq_o[g] = flag_ff[g] && (ctrl_ff[g][`ACP_LVL_MSB:`ACP_LVL_LSB] != 2'b00);
    end

    // Events leave untouched by interrupt level
    assign cmp_event_o = event_pulse;
    assign window_event_o = wevent_ff;
    assign window_irq_level_o = window_ff[`ACP_WLVL_MSB:`ACP_WLVL_LSB];
    assign window_irq_o = wflag_ff && (window_ff[`ACP_WLVL_MSB:`ACP_WLVL_LSB] != 2'b00);
    assign cmp_hyst_small_o = hyst_small_ff;
    assign cmp_hyst_large_o = hyst_large_ff;
    assign cmp_pin_o = pin_ff;
    assign cmp_pin_oe_o = pinout_ff[1:0];

    // ****************************************************************
    // Avalon slave handshake
    // ****************************************************************
    // One wait state: read data is captured on the first edge so it
    // is stable for the whole cycle that waitrequest is low
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_ff != acp_pkg::ACP_BUS_ANSWER);
    assign avs_readdata_o = readdata_ff;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bus_ff <= acp_pkg::ACP_BUS_IDLE;
        end else begin
            case (bus_ff)
                acp_pkg::ACP_BUS_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        bus_ff <= acp_pkg::ACP_BUS_ANSWER;
                    end
                end
                acp_pkg::ACP_BUS_ANSWER: bus_ff <= acp_pkg::ACP_BUS_IDLE;
                default: bus_ff <= acp_pkg::ACP_BUS_IDLE;
            endcase
        end
    end

    assign status = {wstate_ff, state[1], state[0], 1'b0, wflag_ff, flag_ff};

    always_comb begin
        case (idx)
            `ACP_IDX_CTRL0: rd_mux = ctrl_ff[0];
            `ACP_IDX_CTRL1: rd_mux = ctrl_ff[1];
            `ACP_IDX_MUX0: rd_mux = mux_ff[0] & `ACP_MUX_MASK;
            `ACP_IDX_MUX1: rd_mux = mux_ff[1] & `ACP_MUX_MASK;
            `ACP_IDX_PINOUT: rd_mux = pinout_ff;
            `ACP_IDX_WINDOW: rd_mux = window_ff;
            `ACP_IDX_STATUS: rd_mux = status;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            readdata_ff <= 32'h00000000;
        end else if (avs_read_i && (bus_ff == acp_pkg::ACP_BUS_IDLE)) begin
            readdata_ff <= {24'h000000, rd_mux};
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Writes are taken as given; software sets up inputs before enable
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_ff[0] <= `ACP_RST_REG;
            ctrl_ff[1] <= `ACP_RST_REG;
            mux_ff[0] <= `ACP_RST_REG;
            mux_ff[1] <= `ACP_RST_REG;
            pinout_ff <= `ACP_RST_REG;
            window_ff <= `ACP_RST_REG;
        end else if (wr_fire) begin
            case (idx)
                `ACP_IDX_CTRL0: ctrl_ff[0] <= wbyte;
                `ACP_IDX_CTRL1: ctrl_ff[1] <= wbyte;
                `ACP_IDX_MUX0: mux_ff[0] <= wbyte & `ACP_MUX_MASK;
                `ACP_IDX_MUX1: mux_ff[1] <= wbyte & `ACP_MUX_MASK;
                `ACP_IDX_PINOUT: pinout_ff <= wbyte & `ACP_PINOUT_MASK;
                `ACP_IDX_WINDOW: window_ff <= wbyte & `ACP_WINDOW_MASK;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Hysteresis decode, reserved code gives none
    // ****************************************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hyst_small_ff <= 2'b00;
            hyst_large_ff <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                hyst_small_ff[i] <= (ctrl_ff[i][`ACP_HYST_MSB:`ACP_HYST_LSB] == 2'b01);
                hyst_large_ff[i] <= (ctrl_ff[i][`ACP_HYST_MSB:`ACP_HYST_LSB] == 2'b10);
            end
        end
    end

    // ****************************************************************
    // Output to pin
    // ****************************************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_ff <= 2'b00;
        end else begin
            pin_ff <= state & pinout_ff[1:0];
        end
    end

    // ****************************************************************
    // Window monitor
    // ****************************************************************
    // Comparator zero holds the upper bound, comparator one the lower
    always_comb begin
        if (state[0]) begin
            nxt_wstate = acp_pkg::ACP_WIN_ABOVE;
        end else if (state[1]) begin
            nxt_wstate = acp_pkg::ACP_WIN_INSIDE;
        end else begin
            nxt_wstate = acp_pkg::ACP_WIN_BELOW;
        end
        case (wcond)
            acp_pkg::ACP_WIN_OUTSIDE: nxt_wevent = (nxt_wstate != acp_pkg::ACP_WIN_INSIDE)
                && (wstate_ff == acp_pkg::ACP_WIN_INSIDE);
            default: nxt_wevent = (nxt_wstate == wcond) && (wstate_ff != wcond);
        endcase
        if (!wen) begin
            nxt_wstate = acp_pkg::ACP_WIN_ABOVE;
            nxt_wevent = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wstate_ff <= acp_pkg::ACP_WIN_ABOVE;
            wevent_ff <= 1'b0;
        end else begin
            wstate_ff <= nxt_wstate;
            wevent_ff <= nxt_wevent;
        end
    end

    // ****************************************************************
    // Interrupt flags, a set in the clearing cycle wins
    // ****************************************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag_ff <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (event_pulse[i]) begin
                    flag_ff[i] <= 1'b1;
                end else if (cmp_irq_ack_i[i] || (wr_fire && idx == `ACP_IDX_STATUS && wbyte[i])) begin
                    flag_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wflag_ff <= 1'b0;
        end else if (wevent_ff) begin
            wflag_ff <= 1'b1;
        end else if (window_irq_ack_i || (wr_fire && idx == `ACP_IDX_STATUS && wbyte[`ACP_ST_WFLAG_BIT])) begin
            wflag_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_ctrl0_write;
        wr_fire && (idx == `ACP_IDX_CTRL0);
    endsequence

    property p_ctrl_store;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        s_ctrl0_write |=> cmp_enable_o[0] == $past(avs_writedata_i[0]) && cmp_fast_o[0] == $past(avs_writedata_i[3]);
    endproperty
    a_ctrl_store: assert property (p_ctrl_store) else $error("Control write not applied");

    property p_irq_follows;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        event_pulse[0] && (cmp_irq_level_o[1:0] != 2'b00) |=> cmp_irq_o[0];
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("Enabled interrupt did not fire");

    property p_no_irq_level0;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        cmp_irq_level_o[3:2] == 2'b00 |-> !cmp_irq_o[1];
    endproperty
    a_no_irq_level0: assert property (p_no_irq_level0) else $error("Interrupt with zero level");

    property p_ack_clears;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        cmp_irq_ack_i[0] && !event_pulse[0] |=> !flag_ff[0];
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("Acknowledge did not clear flag");

    property p_set_wins;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        event_pulse[1] |=> flag_ff[1];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Event lost against clear");

    sequence s_mux_read;
        avs_read_i && (bus_ff == acp_pkg::ACP_BUS_IDLE) && (idx == `ACP_IDX_MUX0 || idx == `ACP_IDX_MUX1);
    endsequence

    property p_mux_reserved;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        s_mux_read ##1 !avs_waitrequest_o |-> avs_readdata_o[7:6] == 2'b00;
    endproperty
    a_mux_reserved: assert property (p_mux_reserved) else $error("Reserved select bits not zero");

    property p_window_above;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        wen && state[0] |=> wstate_ff == acp_pkg::ACP_WIN_ABOVE;
    endproperty
    a_window_above: assert property (p_window_above) else $error("Window state not above");

    property p_window_inside;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        wen && (wcond == acp_pkg::ACP_WIN_INSIDE) && !state[0] && state[1]
            && (wstate_ff != acp_pkg::ACP_WIN_INSIDE) |=> window_event_o ##1 wflag_ff;
    endproperty
    a_window_inside: assert property (p_window_inside) else $error("Inside window not flagged");

    property p_pin_drive;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        cmp_pin_oe_o[0] && $stable(cmp_pin_oe_o[0]) |-> cmp_pin_o[0] == $past(state[0]);
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("Pin does not follow comparator");

    property p_event_no_level;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(state[0]) && ($past(ctrl_ff[0][`ACP_EDGE_MSB]) == $past(ctrl_ff[0][`ACP_EDGE_LSB])) |-> cmp_event_o[0];
    endproperty
    a_event_no_level: assert property (p_event_no_level) else $error("Event suppressed");

endmodule : acp_top

/* File: test_analog_comparator_pair_control.sv */
`timescale 1ns/10ps

module test_analog_comparator_pair_control;
    logic ref_clk_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, window_event_o, window_irq_o;
    logic window_irq_ack_i;
    logic [4:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0] avs_byteenable_i, cmp_irq_level_o;
    logic [15:0] plus_pin_o, minus_pin_o, plus_lvl, minus_lvl;
    logic [1:0] cmp_raw_i, cmp_enable_o, cmp_fast_o, cmp_hyst_small_o, cmp_hyst_large_o, plus_dac_o, minus_dac_o;
    logic [1:0] minus_bandgap_o, minus_scaler_o, cmp_event_o, cmp_irq_o, window_irq_level_o, cmp_irq_ack_i;
    logic [1:0] cmp_pin_o, cmp_pin_oe_o;
    int error_cnt, checks, ev_n, ev1_n, wev_n, seed;
    logic [7:0] rd, wd;
    int exp_ev[4] = '{2, 0, 1, 1};
    int neg_pin[5] = '{0, 1, 3, 5, 7};

    acp_top i_dut (.ref_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .cmp_raw_i, .cmp_enable_o, .cmp_fast_o,
        .cmp_hyst_small_o, .cmp_hyst_large_o, .plus_pin_o, .plus_dac_o, .minus_pin_o, .minus_dac_o,
        .minus_bandgap_o, .minus_scaler_o, .cmp_event_o, .window_event_o, .cmp_irq_o, .cmp_irq_level_o,
        .window_irq_o, .window_irq_level_o, .cmp_irq_ack_i, .window_irq_ack_i, .cmp_pin_o, .cmp_pin_oe_o);
    acp_core_model i_core (.plus_lvl_i(plus_lvl), .minus_lvl_i(minus_lvl), .raw_o(cmp_raw_i));

    initial begin
        ref_clk_i = 0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        if (cmp_event_o[0] === 1'b1) ev_n <= ev_n + 1;
        if (cmp_event_o[1] === 1'b1) ev1_n <= ev1_n + 1;
        if (window_event_o === 1'b1) wev_n <= wev_n + 1;
    end

    // ****
    // Checking and bus tasks
    // ****
    task automatic results();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic [7:0] st_exp(input logic [1:0] ws, input logic [1:0] st, input logic wf,
        input logic [1:0] fl);
        return {ws, st, 1'b0, wf, fl};
    endfunction : st_exp

    // Wait and data are read at the edge before its updates land; one idle edge between transfers
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        int n;
        avs_address_i <= {a, 2'h0};
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= w;
        avs_read_i <= !w;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        rd = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge ref_clk_i);
        if (n >= 50) begin
            error_cnt++;
            results();
        end
    endtask : bus

    initial begin
        seed = 85162;
        error_cnt = 0;
        checks = 0;
        ev_n = 0;
        sys_rst_i = 1;
        avs_read_i = 0;
        avs_write_i = 0;
        avs_address_i = 0;
        avs_writedata_i = 0;
        avs_byteenable_i = 4'hF;
        cmp_irq_ack_i = 0;
        window_irq_ack_i = 0;
        plus_lvl = 16'h0000;
        minus_lvl = 16'h8080;
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 0;
        @(posedge ref_clk_i);
        chk("irq at reset", {cmp_event_o, cmp_irq_o}, 0);
        for (int i = 0; i < 7; i++) begin
            bus(0, i[2:0], 8'h00);
            chk("reset value", rd, 0);
        end
        for (int k = 0; k < 8; k++) begin
            bus(1, 3'h3, {2'b00, k[2:0], k[2:0]});
            bus(0, 3'h3, 8'h00);
            chk("mux readback", rd, {2'b00, k[2:0], k[2:0]});
            chk("plus decode", {plus_dac_o[1], plus_pin_o[15:8]}, k == 7 ? 9'h100 : 9'h001 << k);
            chk("minus decode", {minus_scaler_o[1], minus_bandgap_o[1], minus_dac_o[1], minus_pin_o[15:8]},
                k < 5 ? 11'h001 << neg_pin[k] : 11'h100 << (k - 5));
        end
        bus(1, 3'h2, 8'h0A);
        bus(1, 3'h4, 8'h01);
        chk("plus0 decode", {plus_dac_o[0], plus_pin_o[7:0]}, 9'h002);
        chk("minus0 decode", {minus_scaler_o[0], minus_bandgap_o[0], minus_dac_o[0], minus_pin_o[7:0]},
            11'h008);
        for (int i = 0; i < 4; i++) begin
            wd = {i[1:0], i[1:0], i[0], i[1:0], 1'b1};
            bus(1, 3'h0, wd & 8'hFE);
            bus(1, 3'h0, wd);
            bus(0, 3'h0, 8'h00);
            chk("ctrl readback", rd, wd);
            chk("fast", cmp_fast_o[0], i[0]);
            chk("hyst", {cmp_hyst_large_o[0], cmp_hyst_small_o[0]}, i == 3 ? 2'b00 : i[1:0]);
            chk("enable", cmp_enable_o[0], 1);
            ev_n = 0;
            wd = $random(seed);
            plus_lvl[7:0] <= {1'b1, wd[6:0] | 7'h01};
            repeat (10) @(posedge ref_clk_i);
            chk("pin out", cmp_pin_o[0], 1);
            plus_lvl[7:0] <= {1'b0, wd[6:0]};
            repeat (10) @(posedge ref_clk_i);
            chk("event count", ev_n, exp_ev[i]);
            chk("irq", cmp_irq_o[0], i != 0 && exp_ev[i] != 0);
            chk("irq level", cmp_irq_level_o[1:0], i[1:0]);
            cmp_irq_ack_i <= 2'b01;
            @(posedge ref_clk_i);
            cmp_irq_ack_i <= 2'b00;
            repeat (2) @(posedge ref_clk_i);
            chk("irq cleared", cmp_irq_o[0], 0);
        end
        bus(1, 3'h0, 8'h00);
        ev_n = 0;
        plus_lvl[7:0] <= 8'hFF;
        repeat (10) @(posedge ref_clk_i);
        chk("disabled events", ev_n, 0);
        plus_lvl <= 16'h0000;
        minus_lvl <= 16'h4080;
        bus(1, 3'h6, 8'h15);
        avs_byteenable_i <= 4'hE;
        bus(1, 3'h6, 8'h00);
        avs_byteenable_i <= 4'hF;
        bus(0, 3'h6, 8'h00);
        chk("lane gated write", rd, 8'h15);
        bus(1, 3'h4, 8'h03);
        bus(1, 3'h1, 8'hDA);
        bus(1, 3'h1, 8'hDB);
        bus(1, 3'h0, 8'h01);
        chk("cmp1 config", {cmp_fast_o[1], cmp_hyst_large_o[1], cmp_hyst_small_o[1], cmp_enable_o[1]}, 4'hB);
        chk("levels", {window_irq_level_o, cmp_irq_level_o[3:2]}, 4'h5);
        bus(0, 3'h7, 8'h00);
        chk("status below", rd, st_exp(2'b10, 2'b00, 1'b0, 2'b00));
        plus_lvl <= 16'h6060;
        repeat (10) @(posedge ref_clk_i);
        chk("window inside", {wev_n[3:0], ev1_n[3:0], cmp_irq_o, window_irq_o}, {4'h1, 4'h1, 3'b101});
        bus(0, 3'h7, 8'h00);
        chk("status inside", rd, st_exp(2'b01, 2'b10, 1'b1, 2'b10));
        bus(1, 3'h7, 8'h06);
        bus(0, 3'h7, 8'h00);
        chk("w1c clear", {rd, cmp_irq_o, window_irq_o}, {st_exp(2'b01, 2'b10, 1'b0, 2'b00), 3'b000});
        ev_n = 0;
        plus_lvl <= 16'h9090;
        repeat (10) @(posedge ref_clk_i);
        chk("above", {ev_n[3:0], wev_n[3:0], cmp_irq_o, cmp_pin_o, cmp_pin_oe_o}, {8'h11, 6'h0F});
        bus(0, 3'h7, 8'h00);
        chk("status above", rd, st_exp(2'b00, 2'b11, 1'b0, 2'b01));
        results();
    end
endmodule : test_analog_comparator_pair_control
